//--- verilog/otg_role_pkg.sv
`default_nettype none
package otg_role_pkg;
   // =====================================================
   // register map (byte addresses)
   localparam logic [11:0] ADDR_ROLE_CTRL = 12'h000;
   localparam logic [11:0] ADDR_INT_STAT  = 12'h004;
   localparam logic [11:0] ADDR_INT_MASK  = 12'h008;
   localparam int          ADDR_W         = 12;
   // =====================================================
   // field positions of the role/session register
   localparam int BIT_B_ROLE   = 7;
   localparam int BIT_FS_PEER  = 6;
   localparam int BIT_LS_PEER  = 5;
   localparam int BIT_VBUS_HI  = 4;
   localparam int BIT_VBUS_LO  = 3;
   localparam int BIT_HOST     = 2;
   localparam int BIT_HOST_REQ = 1;
   localparam int BIT_SESSION  = 0;
   localparam logic [7:0] ROLE_CTRL_RESET = 8'h00;
   // =====================================================
   // vbus level bands
   localparam logic [1:0] VBUS_BELOW_SESS_END = 2'h0;
   localparam logic [1:0] VBUS_SESS_END       = 2'h1;
   localparam logic [1:0] VBUS_A_VALID        = 2'h2;
   localparam logic [1:0] VBUS_VALID          = 2'h3;
   // =====================================================
   // interrupt status bits
   localparam int          NUM_EVENTS   = 4;
   localparam int          EV_SESS_UP   = 0;
   localparam int          EV_SESS_DOWN = 1;
   localparam int          EV_HNP_DONE  = 2;
   localparam int          EV_SOFT_DISC = 3;
   localparam logic [3:0]  INT_RESET    = 4'h0;
   // =====================================================
   typedef enum logic [1:0] {
      HNP_IDLE    = 2'b00,
      HNP_RUN     = 2'b01,
      HNP_FINISH  = 2'b10
   } hnp_state_t;
endpackage : otg_role_pkg
`default_nettype wire

//--- verilog/line_status_if.sv
`default_nettype none
interface line_status_if;
   logic       bRole;
   logic       fsPeer;
   logic       lsPeer;
   logic [1:0] vbusBand;
   logic       acting_as_host;
   logic       suspended;
   logic       sessionActive;
   logic       chirpSeen;
   logic       hnpDone;
   modport source (output bRole, fsPeer, lsPeer, vbusBand, acting_as_host, suspended, sessionActive, chirpSeen, hnpDone);
   modport sink   (input  bRole, fsPeer, lsPeer, vbusBand, acting_as_host, suspended, sessionActive, chirpSeen, hnpDone);
endinterface : line_status_if
`default_nettype wire

//--- verilog/line_status_sync.sv
`default_nettype none
module line_status_sync
   import otg_role_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       bRoleIn,
   input  wire logic       fsPeerIn,
   input  wire logic       lsPeerIn,
   input  wire logic [1:0] vbusBandIn,
   input  wire logic       hostModeIn,
   input  wire logic       suspendIn,
   input  wire logic       sessionIn,
   input  wire logic       chirpIn,
   input  wire logic       hnpDoneIn,
   line_status_if.source   status
);
   localparam int W = 10;
   logic [W-1:0] raw;
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage1_d;
   logic [W-1:0] stage2_q;
   logic [W-1:0] stage2_d;

   assign raw = {bRoleIn, fsPeerIn, lsPeerIn, vbusBandIn, hostModeIn, suspendIn, sessionIn, chirpIn, hnpDoneIn};

   // =====================================================
   // two-flop synchroniser for every phy/line level
   always_comb begin
      stage1_d = raw;
      stage2_d = stage1_q;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= stage1_d;
         stage2_q <= stage2_d;
      end
   end

   assign status.bRole         = stage2_q[9];
   assign status.fsPeer        = stage2_q[8];
   assign status.lsPeer        = stage2_q[7];
   assign status.vbusBand      = stage2_q[6:5];
   assign status.acting_as_host      = stage2_q[4];
   assign status.suspended     = stage2_q[3];
   assign status.sessionActive = stage2_q[2];
   assign status.chirpSeen     = stage2_q[1];
   assign status.hnpDone       = stage2_q[0];
endmodule : line_status_sync
`default_nettype wire

//--- verilog/hnp_sequencer.sv
`default_nettype none
module hnp_sequencer
   import otg_role_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic hostRequest,
   line_status_if.sink status,
   output var  logic hnpStart,
   output var  logic hnpComplete
);
   hnp_state_t state_q;
   hnp_state_t state_d;
   logic       start_d;
   logic       done_d;
   logic       start_q;
   logic       done_q;

   // =====================================================
   // negotiation only from the b role with a pending request
   always_comb begin
      state_d = state_q;
      start_d = 1'b0;
      done_d  = 1'b0;
      case (state_q)
         HNP_IDLE: begin
            if (hostRequest && status.bRole && status.sessionActive && status.suspended) begin
               state_d = HNP_RUN;
               start_d = 1'b1;
            end
         end
         HNP_RUN: begin
            if (status.hnpDone) begin
               state_d = HNP_FINISH;
               done_d  = 1'b1;
            end else if (!status.sessionActive) begin
               state_d = HNP_IDLE;
            end
         end
         HNP_FINISH: begin
            // wait for the phy to drop its done level before rearming
            if (!status.hnpDone) begin
               state_d = HNP_IDLE;
            end
         end
         default: state_d = HNP_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= HNP_IDLE;
         start_q <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         start_q <= start_d;
         done_q  <= done_d;
      end
   end

   assign hnpStart    = start_q;
   assign hnpComplete = done_q;
endmodule : hnp_sequencer
`default_nettype wire

//--- verilog/otg_role_session_control.sv
// =====================================================
// What this block does
// - bit 7 reports role, 1 means B
// - role bit only meaningful during sessions
// - host mode flags full/high-speed peer
// - high-speed told apart by reset chirps
// - host mode flags low-speed peer
// - two-bit vbus level band field
// - host bit set while acting as host
// - B role request starts negotiation on suspend
// - request bit self-clears after negotiation
// - B role hardware sets/clears session
// - clearing session in suspend disconnects
//
// The register addresses and the APB slave port were left to the implementer.
`default_nettype none
module otg_role_session_control
   import otg_role_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        bRoleIn,
   input  wire logic        fsPeerIn,
   input  wire logic        lsPeerIn,
   input  wire logic [1:0]  vbusBandIn,
   input  wire logic        hostModeIn,
   input  wire logic        suspendIn,
   input  wire logic        sessionIn,
   input  wire logic        chirpIn,
   input  wire logic        hnpDoneIn,
   output var  logic        sessionOut,
   output var  logic        srpStart,
   output var  logic        hnpStart,
   output var  logic        softDisconnect,
   output var  logic        irq
);
   line_status_if status ();

   logic                  hnpStartW;
   logic                  hnpCompleteW;
   logic                  host_role_request_q;
   logic                  host_role_request_d;
   logic                  session_q;
   logic                  session_d;
   logic                  fsPeer_q;
   logic                  fsPeer_d;
   logic                  lsPeer_q;
   logic                  lsPeer_d;
   logic                  sessPrev_q;
   logic                  srp_q;
   logic                  srp_d;
   logic                  disc_q;
   logic                  disc_d;
   logic                  discHold_q;
   logic                  discHold_d;
   logic                  hnpOut_q;
   logic [NUM_EVENTS-1:0] intStat_q;
   logic [NUM_EVENTS-1:0] intStat_d;
   logic [NUM_EVENTS-1:0] intMask_q;
   logic [NUM_EVENTS-1:0] intMask_d;
   logic [NUM_EVENTS-1:0] events;
   logic                  irq_q;
   logic                  irq_d;
   logic [31:0]           rdata_q;
   logic [31:0]           rdata_d;
   logic                  ready_q;
   logic                  ready_d;
   logic                  err_q;
   logic                  err_d;
   logic                  setup;
   logic                  access;
   logic                  wrRole;
   logic                  wrStat;
   logic                  wrMask;
   logic                  mapped;
   logic [7:0]            roleView;

   line_status_sync u_sync (
      .clock      (clock),
      .reset_n    (reset_n),
      .bRoleIn    (bRoleIn),
      .fsPeerIn   (fsPeerIn),
      .lsPeerIn   (lsPeerIn),
      .vbusBandIn (vbusBandIn),
      .hostModeIn (hostModeIn),
      .suspendIn  (suspendIn),
      .sessionIn  (sessionIn),
      .chirpIn    (chirpIn),
      .hnpDoneIn  (hnpDoneIn),
      .status     (status)
   );

   hnp_sequencer u_hnp (
      .clock       (clock),
      .reset_n     (reset_n),
      .hostRequest (host_role_request_q),
      .status      (status),
      .hnpStart    (hnpStartW),
      .hnpComplete (hnpCompleteW)
   );

   // =====================================================
   // apb decode: no wait state, answer in the first access cycle
   // writes land at the edge that completes the access, never at setup,
   // so a transfer the master has not finished leaves no trace
   assign setup  = psel && !penable;
   assign access = psel && penable && ready_q;
   assign mapped = (paddr == ADDR_ROLE_CTRL) || (paddr == ADDR_INT_STAT) || (paddr == ADDR_INT_MASK);
   assign wrRole = access && pwrite && (paddr == ADDR_ROLE_CTRL);
   assign wrStat = access && pwrite && (paddr == ADDR_INT_STAT);
   assign wrMask = access && pwrite && (paddr == ADDR_INT_MASK);

   // =====================================================
   // role bit shown as-is; software must gate it with session
   always_comb begin
      roleView                          = 8'h00;
      roleView[BIT_B_ROLE]              = status.bRole;
      roleView[BIT_FS_PEER]             = fsPeer_q;
      roleView[BIT_LS_PEER]             = lsPeer_q;
      roleView[BIT_VBUS_HI:BIT_VBUS_LO] = status.vbusBand;
      roleView[BIT_HOST]                = status.acting_as_host;
      roleView[BIT_HOST_REQ]            = host_role_request_q;
      roleView[BIT_SESSION]             = session_q;
   end

   // =====================================================
   // peer speed flags: only tracked in host mode
   always_comb begin
      fsPeer_d = fsPeer_q;
      lsPeer_d = lsPeer_q;
      if (!status.acting_as_host) begin
         fsPeer_d = 1'b0;
         lsPeer_d = 1'b0;
      end else begin
         // a chirp during peer reset also marks the fast peer
         fsPeer_d = status.fsPeer || status.chirpSeen;
         lsPeer_d = status.lsPeer && !fsPeer_d;
      end
   end

   // =====================================================
   // control bits: host request and session
   always_comb begin
      host_role_request_d = host_role_request_q;
      session_d = session_q;
      srp_d     = 1'b0;
      disc_d    = 1'b0;
      if (wrRole) begin
         // only bits 1 and 0 are writable; status bits ignore writes
         host_role_request_d = pwdata[BIT_HOST_REQ];
         if (status.bRole && status.sessionActive) begin
            // session owned by hardware in the b role; a clear in suspend still disconnects
            if (!pwdata[BIT_SESSION] && status.suspended) begin
               session_d = 1'b0;
               disc_d    = 1'b1;
            end
         end else begin
            session_d = pwdata[BIT_SESSION];
            srp_d     = pwdata[BIT_SESSION] && !session_q && !status.sessionActive;
            disc_d    = !pwdata[BIT_SESSION] && session_q && status.suspended;
         end
      end else if (status.bRole) begin
         // after a software disconnect the bit stays down until the line drops
         session_d = status.sessionActive && !discHold_q;
      end
      // completion clear beats a simultaneous write, else it would be lost
      if (hnpCompleteW) begin
         host_role_request_d = 1'b0;
      end
      // the hold ends once the peer has really ended the session
      discHold_d = (discHold_q || disc_d) && status.sessionActive;
   end

   // =====================================================
   // interrupt status: set wins over write-one-to-clear
   assign events[EV_SESS_UP]   = session_q && !sessPrev_q;
   assign events[EV_SESS_DOWN] = !session_q && sessPrev_q;
   assign events[EV_HNP_DONE]  = hnpCompleteW;
   assign events[EV_SOFT_DISC] = disc_q;

   always_comb begin
      intStat_d = intStat_q;
      intMask_d = intMask_q;
      if (wrStat) begin
         intStat_d = intStat_q & ~pwdata[NUM_EVENTS-1:0];
      end
      // an event in the same cycle as its clear survives
      intStat_d = intStat_d | events;
      if (wrMask) begin
         intMask_d = pwdata[NUM_EVENTS-1:0];
      end
      // from registered status and mask: irq lags the status bit by one cycle, the event by two
      irq_d = |(intStat_q & intMask_q);
   end

   // =====================================================
   // read path
   // read data is taken from state at setup and shown during the access
   always_comb begin
      rdata_d = 32'h0000_0000;
      ready_d = 1'b0;
      err_d   = 1'b0;
      if (setup) begin
         ready_d = 1'b1;
         err_d   = !mapped;
         if (!pwrite) begin
            case (paddr)
               ADDR_ROLE_CTRL: rdata_d[7:0]            = roleView;
               ADDR_INT_STAT:  rdata_d[NUM_EVENTS-1:0] = intStat_q;
               ADDR_INT_MASK:  rdata_d[NUM_EVENTS-1:0] = intMask_q;
               default:        rdata_d                 = 32'h0000_0000;
            endcase
         end
      end
   end

   // =====================================================
   // peer speed flag registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fsPeer_q <= ROLE_CTRL_RESET[BIT_FS_PEER];
         lsPeer_q <= ROLE_CTRL_RESET[BIT_LS_PEER];
      end else begin
         fsPeer_q <= fsPeer_d;
         lsPeer_q <= lsPeer_d;
      end
   end

   // =====================================================
   // control bit and pulse registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         host_role_request_q  <= ROLE_CTRL_RESET[BIT_HOST_REQ];
         session_q  <= ROLE_CTRL_RESET[BIT_SESSION];
         srp_q      <= 1'b0;
         disc_q     <= 1'b0;
         discHold_q <= 1'b0;
         hnpOut_q   <= 1'b0;
      end else begin
         host_role_request_q  <= host_role_request_d;
         session_q  <= session_d;
         srp_q      <= srp_d;
         disc_q     <= disc_d;
         discHold_q <= discHold_d;
         hnpOut_q   <= hnpStartW;
      end
   end

   // =====================================================
   // interrupt registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sessPrev_q <= 1'b0;
         intStat_q  <= INT_RESET;
         intMask_q  <= INT_RESET;
         irq_q      <= 1'b0;
      end else begin
         sessPrev_q <= session_q;
         intStat_q  <= intStat_d;
         intMask_q  <= intMask_d;
         irq_q      <= irq_d;
      end
   end

   // =====================================================
   // bus answer registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q   <= err_d;
      end
   end

   // =====================================================
   // outputs, each straight from a flip-flop
   assign prdata         = rdata_q;
   assign pready         = ready_q;
   assign pslverr        = err_q;
   assign sessionOut     = session_q;
   assign srpStart       = srp_q;
   assign hnpStart       = hnpOut_q;
   assign softDisconnect = disc_q;
   assign irq            = irq_q;
endmodule : otg_role_session_control
`default_nettype wire

//--- verif/otg_peer_model.sv
`default_nettype none
// =====================================================
// far side of the port: cable peer and line detectors
module otg_peer_model (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic [8:0] want,
   input  wire logic [3:0] hnpLag,
   input  wire logic       hnpStart,
   input  wire logic       softDisconnect,
   output wire logic       bRoleIn,
   output wire logic       fsPeerIn,
   output wire logic       lsPeerIn,
   output wire logic [1:0] vbusBandIn,
   output wire logic       hostModeIn,
   output wire logic       suspendIn,
   output wire logic       sessionIn,
   output wire logic       chirpIn,
   output wire logic       hnpDoneIn
);
   logic       discQ;
   logic       runQ;
   logic [3:0] lagQ;
   logic [2:0] doneQ;
   assign {bRoleIn, fsPeerIn, lsPeerIn, vbusBandIn, hostModeIn, suspendIn} = want[8:2];
   assign chirpIn   = want[0];
   assign sessionIn = want[1] && !discQ;
   assign hnpDoneIn = doneQ != 3'h0;
   // done is held a few cycles so the two-flop sync cannot miss it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         discQ <= 1'b0;
         runQ  <= 1'b0;
         lagQ  <= 4'h0;
         doneQ <= 3'h0;
      end else begin
         discQ <= softDisconnect || (discQ && want[1]);
         doneQ <= (doneQ != 3'h0) ? doneQ - 3'h1 : 3'h0;
         if (hnpStart) begin
            runQ <= 1'b1;
            lagQ <= hnpLag;
         end else if (runQ && lagQ != 4'h0) begin
            lagQ <= lagQ - 4'h1;
         end else if (runQ) begin
            runQ  <= 1'b0;
            doneQ <= 3'h4;
         end
      end
   end
endmodule : otg_peer_model
`default_nettype wire

//--- verif/otg_role_session_control_props.sv
`default_nettype none
module otg_role_session_control_props
   import otg_role_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        bRoleIn,
   input wire logic        fsPeerIn,
   input wire logic        lsPeerIn,
   input wire logic [1:0]  vbusBandIn,
   input wire logic        hostModeIn,
   input wire logic        suspendIn,
   input wire logic        sessionIn,
   input wire logic        chirpIn,
   input wire logic        hnpDoneIn,
   input wire logic        sessionOut,
   input wire logic        srpStart,
   input wire logic        hnpStart,
   input wire logic        softDisconnect,
   input wire logic        irq
);
   logic setupW;
   logic badA;
   logic roleWr;
   logic roleRd;
   logic accessW;
   assign setupW  = psel && !penable;
   assign accessW = psel && penable && pready;
   assign badA    = paddr != ADDR_ROLE_CTRL && paddr != ADDR_INT_STAT && paddr != ADDR_INT_MASK;
   assign roleWr  = accessW && pwrite && paddr == ADDR_ROLE_CTRL;
   assign roleRd = setupW && !pwrite && paddr == ADDR_ROLE_CTRL;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_ready_next: assert property (setupW |=> pready && penable) else $error("no answer after setup");
   a_ready_single: assert property (pready |=> !pready) else $error("ready held two cycles");
   a_unmapped_err: assert property (setupW && badA |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_role_mirror: assert property ($stable({bRoleIn, vbusBandIn, hostModeIn})[*4] ##0 roleRd
      |=> prdata[7] == bRoleIn && prdata[4:2] == {vbusBandIn, hostModeIn}) else $error("status bits wrong");
   a_speed_flags: assert property ($stable({hostModeIn, fsPeerIn, lsPeerIn, chirpIn})[*5] ##0 roleRd
      |=> prdata[6:5] == (hostModeIn ? {fsPeerIn | chirpIn, lsPeerIn & !(fsPeerIn | chirpIn)} : 2'h0))
      else $error("peer speed flags wrong");
   a_srp_cause: assert property (srpStart |-> $past(roleWr && pwdata[0])) else $error("srp without write");
   a_disc_cause: assert property (softDisconnect |-> $past(roleWr && !pwdata[0] && sessionOut))
      else $error("disconnect without clear");
   a_hnp_cause: assert property (hnpStart |-> bRoleIn && suspendIn) else $error("negotiation out of state");
   a_session_a: assert property ((!bRoleIn)[*4] ##0 roleWr |=> sessionOut == $past(pwdata[0]))
      else $error("session write lost");
   a_irq_masked: assert property (accessW && pwrite && paddr == ADDR_INT_MASK && pwdata == 32'h0 |=> ##1 !irq)
      else $error("irq with all masked");
   c_srp: cover property (srpStart);
   c_hnp: cover property (hnpStart);
   c_disc: cover property (softDisconnect);
endmodule : otg_role_session_control_props
bind otg_role_session_control otg_role_session_control_props otg_role_session_control_props_i (.clock, .reset_n,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bRoleIn, .fsPeerIn, .lsPeerIn,
   .vbusBandIn, .hostModeIn, .suspendIn, .sessionIn, .chirpIn, .hnpDoneIn, .sessionOut, .srpStart, .hnpStart,
   .softDisconnect, .irq);
`default_nettype wire

//--- verif/otg_role_session_control_tb.sv
`default_nettype none
module otg_role_session_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import otg_role_pkg::*;
   logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        bRoleIn, fsPeerIn, lsPeerIn, hostModeIn, suspendIn, sessionIn, chirpIn, hnpDoneIn;
   logic [1:0]  vbusBandIn;
   logic        sessionOut, srpStart, hnpStart, softDisconnect, irq;
   logic [8:0]  want;
   logic [3:0]  hnpLag;
   int          nFail, checksDone, srpCnt, hnpCnt, discCnt, i, k;
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   otg_role_session_control otg_role_session_control_i (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bRoleIn, .fsPeerIn, .lsPeerIn, .vbusBandIn, .hostModeIn, .suspendIn,
      .sessionIn, .chirpIn, .hnpDoneIn, .sessionOut, .srpStart, .hnpStart, .softDisconnect, .irq);
   otg_peer_model otg_peer_model_i (.clock, .reset_n, .want, .hnpLag, .hnpStart, .softDisconnect, .bRoleIn,
      .fsPeerIn, .lsPeerIn, .vbusBandIn, .hostModeIn, .suspendIn, .sessionIn, .chirpIn, .hnpDoneIn);
   always @(posedge clock) begin
      if (srpStart === 1'b1) srpCnt++;
      if (hnpStart === 1'b1) hnpCnt++;
      if (softDisconnect === 1'b1) discCnt++;
   end
   // =====================================================
   // reference model and bus tasks
   function automatic logic [31:0] role(input logic [8:0] v, input logic hr, input logic s);
      logic fs;
      fs = v[7] | v[0];
      return {24'h0, v[8], v[3] & fs, v[3] & v[6] & !fs, v[5:4], v[3], hr, s};
   endfunction : role
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         nFail++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         nFail++;
         end_sim();
      end
   endtask : apb
   // line inputs pass a two-flop sync, flags one more
   task automatic settle;
      repeat (5) @(posedge clock);
   endtask : settle
   // =====================================================
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      want = 9'h000;
      hnpLag = 4'h3;
      reset_n = 1'b0;
      {nFail, checksDone, srpCnt, hnpCnt, discCnt} = '0;
      void'($urandom(36602));
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk({24'h0, ROLE_CTRL_RESET}, rd);
      apb(1'b0, ADDR_INT_STAT, 32'h0); chk(32'h0, rd);
      apb(1'b0, ADDR_INT_MASK, 32'h0); chk(32'h0, rd);
      apb(1'b1, ADDR_ROLE_CTRL, 32'hFF);
      apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk(32'h3, rd);
      chk(32'h1, 32'(srpCnt));
      apb(1'b1, ADDR_ROLE_CTRL, 32'h0);
      apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk(32'h0, rd);
      for (i = 0; i < 8; i++) begin
         want <= (9'($urandom) & 9'h1C9) | (9'(i % 4) << 4);
         settle();
         apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk(role(want, 1'b0, 1'b0), rd);
      end
      // b-side session up and down, then the interrupt path
      apb(1'b1, ADDR_INT_STAT, 32'hF);
      apb(1'b0, ADDR_INT_STAT, 32'h0); chk(32'h0, rd);
      want <= 9'h102;
      settle();
      apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk(role(9'h102, 1'b0, 1'b1), rd);
      want <= 9'h100;
      settle();
      apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk(role(9'h100, 1'b0, 1'b0), rd);
      apb(1'b0, ADDR_INT_STAT, 32'h0); chk(32'h3, rd & 32'h3);
      apb(1'b1, ADDR_INT_MASK, 32'h2); settle(); chk(32'h1, {31'h0, irq});
      apb(1'b1, ADDR_INT_STAT, 32'h2); settle(); chk(32'h0, {31'h0, irq});
      apb(1'b1, ADDR_INT_STAT, 32'hF);
      apb(1'b1, ADDR_INT_MASK, 32'h0);
      // negotiation request, then suspend
      hnpLag <= 4'($urandom_range(2, 9));
      want <= 9'h132;
      settle();
      apb(1'b1, ADDR_ROLE_CTRL, 32'h2);
      apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk(role(9'h132, 1'b1, 1'b1), rd);
      want <= 9'h136;
      for (k = 0; k < 20 && hnpCnt == 0; k++) @(posedge clock);
      chk(32'h1, 32'(hnpCnt));
      k = 0;
      do begin
         apb(1'b0, ADDR_ROLE_CTRL, 32'h0);
         k++;
      end while (rd[1] !== 1'b0 && k < 10);
      chk(role(9'h136, 1'b0, 1'b1), rd);
      apb(1'b0, ADDR_INT_STAT, 32'h0); chk(32'h4, rd & 32'h4);
      // clearing the session while suspended
      apb(1'b1, ADDR_ROLE_CTRL, 32'h0); settle(); chk(32'h1, 32'(discCnt));
      settle();
      apb(1'b0, ADDR_ROLE_CTRL, 32'h0); chk(role(9'h134, 1'b0, 1'b0), rd);
      apb(1'b0, ADDR_INT_STAT, 32'h0); chk(32'h8, rd & 32'h8);
      apb(1'b0, 12'h00C, 32'h0); chk(32'h0, rd);
      chk(32'h1, {31'h0, err});
      apb(1'b1, 12'h010, 32'hFF); chk(32'h1, {31'h0, err});
      end_sim();
   end
endmodule : otg_role_session_control_tb
`default_nettype wire
